// >>> aod_chan.sv
// One channel of the over-range detector: magnitude, compare, hold timer.
// Assumes the sample arrives registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module aod_chan (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic valid_i,
  input wire logic [11:0] sample_i,
  input wire logic enable_i,
  input wire logic [7:0] thresh_i,
  input wire logic [2:0] hold_sel_i,
  output logic flag_o,
  output logic event_o
);
  // All state in one struct
  typedef struct packed {
    logic [10:0] cnt;
    logic flag;
    logic evt;
  } aod_chan_s;

  aod_chan_s st_q;
  aod_chan_s st_d;
  logic [10:0] mag;
  logic hit;
  logic [10:0] hold_len;

  // Absolute value; -2048 saturates to 2047
  always_comb
  begin
    if (sample_i == 12'h800)
      mag = 11'h7ff;
    else if (sample_i[11])
      mag = 11'((~sample_i) + 12'h001);
    else
      mag = sample_i[10:0];
  end

  // Upper eight magnitude bits against common threshold
  assign hit = valid_i && enable_i && (mag[10:3] >= thresh_i);
  // Hold length 8 << sel cycles
  assign hold_len = 11'(11'h008 << hold_sel_i);

  // Hold timer, restarted by each hit
  always_comb
  begin
    st_d = st_q;
    st_d.evt = hit;
    if (!enable_i)
    begin
      st_d.cnt = 11'h000;  // Disabled keeps flag low
      st_d.flag = 1'b0;
    end
    else if (hit)
    begin
      st_d.cnt = 11'(hold_len - 11'h001);  // Restart on every hit
      st_d.flag = 1'b1;
    end
    else if (st_q.cnt != 11'h000)
    begin
      st_d.cnt = st_q.cnt - 11'h001;
    end
    else
    begin
      st_d.flag = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign flag_o = st_q.flag;
  assign event_o = st_q.evt;
endmodule : aod_chan
`default_nettype wire

// >>> aod_gain_model.sv
// Downstream gain logic: steps gain down when flags rise from all clear while samples flow.
// Assumes flags and sample valid come straight from the detector.
`timescale 1ns/1ps
`default_nettype none
module aod_gain_model (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] range_flag_i,
  input wire logic sample_valid_i,
  output logic [7:0] gain_o
);
  logic any_q; // Any flag last cycle
  // Onsets only count while samples flow; an onset during a calibration gap is dropped
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
    begin
      any_q <= 1'b0;
      gain_o <= 8'h10;
    end
    else
    begin
      any_q <= |range_flag_i;
      if (|range_flag_i && !any_q && sample_valid_i)
        gain_o <= gain_o - 8'h01;
    end
endmodule : aod_gain_model
`default_nettype wire

// >>> aod_pkg.sv
// Package for the over-range detector: register map, field layout, resets.
// Assumes a 32-bit classic Wishbone slave port and one 200 MHz clock.
package aod_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] THRESH_OFS = 8'h04;
  localparam logic [7:0] FSCALE_OFS = 8'h08;
  localparam logic [7:0] CAL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IMASK_OFS = 8'h14;
  localparam logic [7:0] FLAGS_OFS = 8'h18;
  localparam logic [7:0] TRIM_BASE_OFS = 8'h20;
  // Control and calibration register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HOLD_LSB = 4;
  localparam int CTRL_CAL_BG_BIT = 8;
  localparam int CAL_START_BIT = 0;
  localparam int CAL_BUSY_BIT = 1;
  // Reset values
  localparam logic [7:0] THRESH_RST = 8'hff;
  localparam logic [2:0] HOLD_RST = 3'h0;
  localparam logic [7:0] FSCALE_RST = 8'h80;
  // Trim field width and core count (quad variant)
  localparam int TRIM_W = 8;
  localparam int CORE_CNT = 6;
  localparam int TRIM_CNT = 8;
  // Smallest hold length is eight cycles
  localparam int HOLD_BASE_LOG2 = 3;
  // Foreground calibration length in cycles
  localparam int FG_CAL_CYCLES = 64;
  // Calibration controller states
  typedef enum logic [1:0] {
    AOD_CAL_IDLE,
    AOD_CAL_FG,
    AOD_CAL_BG
  } aod_cal_e;
endpackage : aod_pkg

// >>> aod_props.sv
// Checker for the over-range detector top, on its ports only.
// Assumes one clock domain with an active-high async reset.
`timescale 1ns/1ps
`default_nettype none
module aod_props #(
  parameter int CHAN_CNT = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [CHAN_CNT*12-1:0] sample_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [CHAN_CNT-1:0] range_flag_o,
  input wire logic [CHAN_CNT*12-1:0] sample_o,
  input wire logic sample_valid_o,
  input wire logic [7:0] fullscale_setting_o,
  input wire logic [63:0] core_input_offset_trim_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // A taken request is answered on the next cycle
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  chk_flag_hold: assert property (
    $rose(range_flag_o[0]) |-> range_flag_o[0][*8])
    else $error("flag a short");
  chk_last_fall: assert property (
    $fell(range_flag_o[CHAN_CNT-1])
    |-> $past(range_flag_o[CHAN_CNT-1], 8)) else $error("flag d short");
  chk_sample_pass: assert property (
    sample_valid_o |-> sample_o == $past(sample_i))
    else $error("sample not captured");
  chk_cal_freeze: assert property (
    !sample_valid_o && !$past(sample_valid_o) |-> $stable(sample_o))
    else $error("sample moved in calibration");
  chk_fs_write: assert property (
    $changed(fullscale_setting_o) |-> wb_ack_o && wb_we_i)
    else $error("full-scale moved");
  chk_trim_write: assert property (
    $changed(core_input_offset_trim_o) |-> wb_ack_o && wb_we_i)
    else $error("trim moved");
  cov_flag: cover property ($rose(range_flag_o[0]));
  cov_cal: cover property ($fell(sample_valid_o));
  cov_read: cover property (wb_ack_o && !wb_we_i);
endmodule : aod_props
bind aod_top aod_props #(.CHAN_CNT(CHAN_CNT)) u_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sample_i(sample_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .range_flag_o(range_flag_o),
  .sample_o(sample_o), .sample_valid_o(sample_valid_o),
  .fullscale_setting_o(fullscale_setting_o),
  .core_input_offset_trim_o(core_input_offset_trim_o));
`default_nettype wire

// >>> aod_top.sv
// Over-range detector top: sample capture, one, two or four channels, Wishbone regs,
// trims, calibration control and interrupt.
// Assumes samples are on ref_clk_i, one per cycle per channel.
// Register map, byte offsets on the 8-bit address
//   0x00 control: bit 0 detector enable, bits 6:4 hold select,
//        bit 8 background calibration request
//   0x04 shared threshold, lane 0 only
//   0x08 full-scale setting, lane 0 only
//   0x0c calibration: write bit 0 starts foreground when idle, read bit 1 foreground busy
//   0x10 sticky status, one bit per channel, write one to clear
//   0x14 interrupt mask, one means enabled
//   0x18 live flags, read only
//   0x20 + 4*i offset trim i, eight entries, lane 0 only
//
// Timing seen from the bus
//   Every taken request is answered one cycle later with a one-cycle ack.
//   Unmapped addresses are acked too: writes vanish, reads return zero.
//
// Timing seen from the flag pins
//   Sample registered at edge k, compared at k+1, flag visible after k+1.
//   The flag then stands for the full hold length after the last hit.
//
// Limitations
//   Calibration here only sequences the swap pattern and the sample gap;
//   the analog work itself lives outside this block.
//   A status event and a same-cycle clear leave the bit set, so software
//   never loses an event that lands during its own clear.
`timescale 1ns/1ps
`default_nettype none
module aod_top #(
  parameter int CHAN_CNT = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Converted samples, one per channel per clock
  input wire logic [CHAN_CNT*12-1:0] sample_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Over-range pins, range_flag_a..d
  output logic [CHAN_CNT-1:0] range_flag_o,
  // Captured samples, held during foreground calibration
  output logic [CHAN_CNT*12-1:0] sample_o,
  output logic sample_valid_o,
  // Analog trim settings, core swap pattern and interrupt
  output logic [7:0] fullscale_setting_o,
  output logic [aod_pkg::TRIM_CNT*aod_pkg::TRIM_W-1:0] core_input_offset_trim_o,
  output logic [aod_pkg::CORE_CNT-1:0] core_swap_o,
  output logic irq_o
);
  // Variant check: single, dual or quad only
  if (CHAN_CNT != 1 && CHAN_CNT != 2 && CHAN_CNT != 4)
    $error("CHAN_CNT must be 1, 2 or 4");

  // All registered state of the top
  typedef struct packed {
    // Detector on
    logic overrange_enable;
    // Background calibration requested
    logic bg_cal;
    // Hold length select, 8 << value cycles
    logic [2:0] overrange_hold_select;
    // Threshold shared by every channel
    logic [7:0] overrange_threshold;
    // Full-scale setting for all inputs
    logic [7:0] fullscale;
    // Offset trims, one byte per core and input
    logic [aod_pkg::TRIM_CNT*aod_pkg::TRIM_W-1:0] trim;
    // Sticky over-range events
    logic [CHAN_CNT-1:0] status;
    // Interrupt enables
    logic [CHAN_CNT-1:0] imask;
    // Calibration controller state
    aod_pkg::aod_cal_e cal;
    // Foreground countdown or background rotation timer
    logic [6:0] cal_cnt;
    // Core swap pattern
    logic [aod_pkg::CORE_CNT-1:0] swap;
    // Captured samples
    logic [CHAN_CNT*12-1:0] smp;
    // Captured samples are fresh
    logic smp_vld;
    // Read data, zero outside an ack
    logic [31:0] rdata;
    // Bus acknowledge pulse
    logic ack;
    // Level interrupt
    logic irq;
  } aod_top_s;

  aod_top_s st_q;
  aod_top_s st_d;
  logic [CHAN_CNT-1:0] flag_w;
  logic [CHAN_CNT-1:0] evt_w;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wmask;

  // Bus request for a fresh cycle; ack clears before next one
  assign wb_req = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign wb_wr = wb_req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Byte-lane merge, used by the control and interrupt mask writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Trim register index decode, used for read and write
  function automatic logic trim_hit(input logic [7:0] adr, input int idx);
    trim_hit = (adr == 8'(aod_pkg::TRIM_BASE_OFS + 8'(idx * 4)));
  endfunction : trim_hit

  // Detector channels, one per flag pin
  for (genvar c = 0; c < CHAN_CNT; c++)
  begin : g_chan
    aod_chan u_chan (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .valid_i(st_q.smp_vld),
      .sample_i(st_q.smp[c*12 +: 12]),
      .enable_i(st_q.overrange_enable),
      .thresh_i(st_q.overrange_threshold),  // Shared value
      .hold_sel_i(st_q.overrange_hold_select),
      .flag_o(flag_w[c]),
      .event_o(evt_w[c])
    );
  end

  // Next-state logic: capture, calibration, registers, interrupt
  always_comb
  begin
    logic [31:0] cw;
    cw = '0;
    st_d = st_q;
    st_d.ack = wb_req;
    // Sample capture each clock, halted in foreground cal
    if (st_q.cal != aod_pkg::AOD_CAL_FG)
    begin
      st_d.smp = sample_i;
      st_d.smp_vld = 1'b1;
    end
    else
    begin
      st_d.smp_vld = 1'b0;
    end
    // Calibration sequencing and core swapping
    case (st_q.cal)
      aod_pkg::AOD_CAL_IDLE:
      begin
        st_d.swap = '0;
        if (st_q.bg_cal)
          st_d.cal = aod_pkg::AOD_CAL_BG;
      end
      aod_pkg::AOD_CAL_FG:
      begin
        // Sampling stops until the count ends
        st_d.swap = '1;
        if (st_q.cal_cnt == 7'h00)
          st_d.cal = aod_pkg::AOD_CAL_IDLE;
        else
          st_d.cal_cnt = st_q.cal_cnt - 7'h01;
      end
      aod_pkg::AOD_CAL_BG:
      begin
        // Rotate one spare core through while converting
        st_d.cal_cnt = st_q.cal_cnt + 7'h01;
        if (st_q.cal_cnt == 7'h7f)
          st_d.swap = (st_q.swap == '0) ? aod_pkg::CORE_CNT'(1)
                    : {st_q.swap[aod_pkg::CORE_CNT-2:0],
                       st_q.swap[aod_pkg::CORE_CNT-1]};
        if (!st_q.bg_cal)
          st_d.cal = aod_pkg::AOD_CAL_IDLE;
      end
      default:
        st_d.cal = aod_pkg::AOD_CAL_IDLE;
    endcase
    // Sticky status; set beats a same-cycle clear
    if (wb_wr && wb_adr_i == aod_pkg::STATUS_OFS)
      st_d.status = st_q.status & ~(wb_dat_i[CHAN_CNT-1:0] &
                                    wmask[CHAN_CNT-1:0]);
    st_d.status = st_d.status | evt_w;
    // Register writes
    if (wb_wr)
    begin
      case (wb_adr_i)
        aod_pkg::CTRL_OFS:
        begin
          cw = merge({23'h0, st_q.bg_cal, 1'b0, st_q.overrange_hold_select,
                      3'h0, st_q.overrange_enable}, wb_dat_i, wmask);
          st_d.overrange_enable = cw[aod_pkg::CTRL_EN_BIT];
          st_d.overrange_hold_select = cw[aod_pkg::CTRL_HOLD_LSB +: 3];
          st_d.bg_cal = cw[aod_pkg::CTRL_CAL_BG_BIT];
        end
        aod_pkg::THRESH_OFS:
          st_d.overrange_threshold = wb_sel_i[0] ? wb_dat_i[7:0]
                                   : st_q.overrange_threshold;
        aod_pkg::FSCALE_OFS:
          // One value drives every input
          st_d.fullscale = wb_sel_i[0] ? wb_dat_i[7:0] : st_q.fullscale;
        aod_pkg::CAL_OFS:
          if (wb_sel_i[0] && wb_dat_i[aod_pkg::CAL_START_BIT] &&
              st_q.cal == aod_pkg::AOD_CAL_IDLE)
          begin
            st_d.cal = aod_pkg::AOD_CAL_FG;
            st_d.cal_cnt = 7'(aod_pkg::FG_CAL_CYCLES - 1);
          end
        aod_pkg::IMASK_OFS:
        begin
          // Merge a full word first, then keep the live channels
          cw = merge(32'(st_q.imask), wb_dat_i, wmask);
          st_d.imask = cw[CHAN_CNT-1:0];
        end
        default:
          ;
      endcase
      // Per core/input trim, signed, about +/-33 mV
      for (int t = 0; t < aod_pkg::TRIM_CNT; t++)
        if (trim_hit(wb_adr_i, t) && wb_sel_i[0])
          st_d.trim[t*aod_pkg::TRIM_W +: aod_pkg::TRIM_W] = wb_dat_i[7:0];
    end
    // Read data, zero for unmapped addresses
    st_d.rdata = '0;
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        aod_pkg::CTRL_OFS:
          st_d.rdata = {23'h0, st_q.bg_cal, 1'b0,
                        st_q.overrange_hold_select, 3'h0,
                        st_q.overrange_enable};
        aod_pkg::THRESH_OFS:
          st_d.rdata = {24'h0, st_q.overrange_threshold};
        aod_pkg::FSCALE_OFS:
          st_d.rdata = {24'h0, st_q.fullscale};
        aod_pkg::CAL_OFS:
          st_d.rdata = {30'h0, st_q.cal == aod_pkg::AOD_CAL_FG, 1'b0};
        aod_pkg::STATUS_OFS:
          st_d.rdata = 32'(st_q.status);
        aod_pkg::IMASK_OFS:
          st_d.rdata = 32'(st_q.imask);
        aod_pkg::FLAGS_OFS:
          st_d.rdata = 32'(flag_w);
        default:
          st_d.rdata = '0;
      endcase
      for (int t = 0; t < aod_pkg::TRIM_CNT; t++)
        if (trim_hit(wb_adr_i, t))
          st_d.rdata = {24'h0, st_q.trim[t*aod_pkg::TRIM_W +: aod_pkg::TRIM_W]};
    end
    // Level interrupt from unmasked sticky bits
    st_d.irq = |(st_d.status & st_d.imask);
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q <= '0;
      st_q.overrange_threshold <= aod_pkg::THRESH_RST;
      st_q.overrange_hold_select <= aod_pkg::HOLD_RST;
      st_q.fullscale <= aod_pkg::FSCALE_RST;
      st_q.cal <= aod_pkg::AOD_CAL_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs, all from flip-flops
  assign wb_dat_o = st_q.rdata;
  assign wb_ack_o = st_q.ack;
  assign range_flag_o = flag_w;  // Registered in the channel
  assign sample_o = st_q.smp;
  assign sample_valid_o = st_q.smp_vld;
  assign fullscale_setting_o = st_q.fullscale;
  assign core_input_offset_trim_o = st_q.trim;
  assign core_swap_o = st_q.swap;
  assign irq_o = st_q.irq;
endmodule : aod_top
`default_nettype wire

// >>> tb_top.sv
// Bench for the over-range detector: flags, hold, irq, regs, cal.
// Assumes aod_top with four channels and the gain model beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Row: sample, threshold, expected flag
  typedef struct packed {logic [11:0] s; logic [7:0] t; logic f;} aod_row_s;
  aod_row_s rows [7] = '{'{12'h800, 8'hff, 1'b1}, '{12'h7ff, 8'hff, 1'b1},
    '{12'h7f0, 8'hff, 1'b0}, '{12'h810, 8'hfe, 1'b1},
    '{12'h810, 8'hff, 1'b0}, '{12'h000, 8'h01, 1'b0},
    '{12'hff0, 8'h02, 1'b1}};
  logic clk = 0, rst = 1, cyc = 0, we = 0, ack, vld, irq;
  logic [7:0] adr = 0, fs, gain;
  logic [31:0] wd = 0, rd, dat;
  logic [47:0] smp = 0, smp_o;
  logic [3:0] flg;
  logic [63:0] trim;
  logic [5:0] swp, s0;
  int fails = 0, cmp_count = 0, n;
  always #2.5 clk = ~clk;
  aod_top #(.CHAN_CNT(4)) DUT (.ref_clk_i(clk), .reset_i(rst),
    .sample_i(smp), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .range_flag_o(flg), .sample_o(smp_o),
    .sample_valid_o(vld), .fullscale_setting_o(fs),
    .core_input_offset_trim_o(trim), .core_swap_o(swp), .irq_o(irq));
  aod_gain_model u_gain (.ref_clk_i(clk), .reset_i(rst),
    .range_flag_i(flg), .sample_valid_i(vld), .gain_o(gain));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; ack seen mid-cycle, released on the next edge
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    // No cycle count assumed; only the watchdog ends a hung wait
    do @(negedge clk); while (ack !== 1'b1);
    rd = dat;
    @(posedge clk);
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : bus
  // One sample on every channel, then quiet input
  task automatic hit(input logic [11:0] s);
    @(posedge clk);
    smp <= {4{s}};
    @(posedge clk);
    smp <= '0;
  endtask : hit
  // High cycles of flag a over a window longer than any hold
  task automatic cnt(output int len);
    len = 0;
    repeat (1100) @(negedge clk) len += int'(flg[0] === 1'b1);
  endtask : cnt
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Watchdog well past the expected run length
  initial
  begin
    #200000;
    fails++;
    final_report();
  end
  initial
  begin
    int len;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(fs, aod_pkg::FSCALE_RST);
    bus(0, aod_pkg::THRESH_OFS, 0);
    chk(rd, aod_pkg::THRESH_RST);
    bus(0, 8'hfc, 0);
    chk(rd, 0);
    bus(1, aod_pkg::CTRL_OFS, 1);
    foreach (rows[i])
    begin
      bus(1, aod_pkg::THRESH_OFS, rows[i].t);
      hit(rows[i].s);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(flg, {4{rows[i].f}});
      repeat (12) @(posedge clk);
    end
    chk(gain, 8'h0c);
    bus(1, aod_pkg::THRESH_OFS, 8'hff);
    bus(1, aod_pkg::IMASK_OFS, 32'hf);
    hit(12'h800);
    repeat (4) @(negedge clk);
    chk(irq, 1);
    bus(0, aod_pkg::STATUS_OFS, 0);
    chk(rd[3:0], 4'hf);
    bus(1, aod_pkg::STATUS_OFS, 32'hf);
    bus(0, aod_pkg::STATUS_OFS, 0);
    chk({rd[3:0], irq}, 5'h0);
    bus(1, aod_pkg::IMASK_OFS, 0);
    hit(12'h800);
    repeat (4) @(negedge clk);
    chk(irq, 0);
    repeat (12) @(posedge clk);
    for (int h = 0; h < 8; h++)
    begin
      bus(1, aod_pkg::CTRL_OFS, 32'(h << 4 | 1));
      fork
        cnt(len);
        hit(12'h800);
      join
      chk(len, 8 << h);
    end
    bus(1, aod_pkg::CTRL_OFS, 1);
    fork
      cnt(len);
      begin
        hit(12'h800);
        repeat (3) @(posedge clk);
        hit(12'h800);
      end
    join
    chk(len, 13);
    bus(1, aod_pkg::CTRL_OFS, 0);
    fork
      cnt(len);
      hit(12'h800);
    join
    chk(len, 0);
    bus(1, aod_pkg::FSCALE_OFS, 8'h5a);
    chk(fs, 8'h5a);
    for (int i = 0; i < 8; i++)
      bus(1, aod_pkg::TRIM_BASE_OFS + 8'(4 * i), 32'(i * 16 + 3));
    chk(trim, 64'h7363534333231303);
    bus(1, aod_pkg::CAL_OFS, 1);
    bus(0, aod_pkg::CAL_OFS, 0);
    chk({rd[1], vld}, 2'b10);
    repeat (70) @(negedge clk);
    chk(vld, 1);
    s0 = swp;
    bus(1, aod_pkg::CTRL_OFS, 32'h100);
    repeat (300) @(negedge clk);
    chk(swp !== s0, 1);
    chk(vld, 1);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
